//--- hw/eirq_status.sv
// External request status register with edge/level detection and bus slave.
// Register map, byte offsets on the slave port:
//   0x0 status: pin levels in bits 15..8, request flags in bits 7..0.
//   0x4 sense: two bits per pin, pin i in bits 2i+1..2i.
//   0x8 events: a bit is set whenever its flag rises; write one to clear.
//   0xC mask: lets each event bit through to the interrupt output.
//
// Every access costs two cycles. The request is taken while the slave is
// idle, and waitrequest is low only in the answer cycle that follows.
// Read data is caught at the take edge, so the answer shows the register
// as it stood when the request was taken.
//
// Edge flags are cleared only by a zero-write that follows a status read
// which showed the flag set, or by an accept pulse; a fresh edge in the
// same cycle wins over either clear. Level flags ignore all writes.
//
// Pins pass two flip-flops before detection, so a pin change reaches the
// flags two cycles after the edge that first samples it. The flags are
// also brought out on req_flag for the interrupt controller, and irq_out
// follows the masked event bits one cycle late.
//
// After reset every pin is in level mode with its flag clear, the mask is
// clear and no event is pending, so irq_out stays low until software
// enables it. Pin levels read high after reset until the pins pass the synchroniser.
//
// Byte lane 0 carries flags, events and mask; the sense register uses
// lanes 0 and 1. Lanes 2 and 3 are ignored and read back as zero, as do
// the offsets that hold no register.
//
// Limitations: a pin must hold a level for at least one clock to be seen,
// and shorter pulses may be missed entirely. Accept pulses act on edge
// flags only; a level flag always follows its pin.
`timescale 1ns/100ps
`default_nettype none

module eirq_status #(
    parameter int NPINS = eirq_pkg::NUM_PINS
) (
    input  wire logic                        core_clk,
    input  wire logic                        arst_n,
    input  wire logic [eirq_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [NPINS-1:0]            ext_req_pin,
    input  wire logic [NPINS-1:0]            irq_accept,
    output logic      [NPINS-1:0]            req_flag,
    output logic                             irq_out
);

    // Slave sequencing states: an access is answered one cycle after taken.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } eirq_bus_t;

    // Registered state.
    eirq_bus_t              bus_q;
    logic [NPINS-1:0]       sync1_q;
    logic [NPINS-1:0]       sync2_q;
    logic [NPINS-1:0]       prev_q;
    logic [NPINS-1:0]       flag_q;
    logic [NPINS-1:0]       armed_q;
    logic [2*NPINS-1:0]     sense_q;
    logic [NPINS-1:0]       evt_q;
    logic [NPINS-1:0]       mask_q;
    logic [31:0]            rdata_q;
    logic                   irq_q;
    // Combinational decode and next-state values.
    logic [NPINS-1:0]       edge_hit;
    logic [NPINS-1:0]       level_mode;
    logic [NPINS-1:0]       flag_d;
    logic [NPINS-1:0]       armed_d;
    logic                   acc;
    logic                   wr_acc;
    logic                   rd_acc;
    logic [15:0]            status_word;
    logic [NPINS-1:0]       pin_fell;
    logic [NPINS-1:0]       pin_rose;
    logic [NPINS-1:0]       flag_rise;
    logic [NPINS-1:0]       arm_req;
    logic [NPINS-1:0]       zero_wr;
    logic                   sel_status;
    logic                   sel_sense;
    logic                   sel_evt;
    logic                   sel_mask;
    logic                   wr_status;
    logic                   wr_sense_lo;
    logic                   wr_sense_hi;
    logic                   wr_evt;
    logic                   wr_mask;
    logic [31:0]            rd_word;

    // Returns the detection-mode code of one pin from the sense field.
    function automatic logic [1:0] sense_of(input logic [2*NPINS-1:0] s,
                                            input int i);
        sense_of = s[2*i +: 2];
    endfunction

    // True when the bus address selects the register at the given offset.
    function automatic logic addr_is(input logic [eirq_pkg::ADDR_W-1:0] a,
                                     input logic [3:0]                  off);
        addr_is = (a == off);
    endfunction

    // An access is taken in idle; waitrequest drops in the answer cycle.
    assign acc    = (avs_read | avs_write) && (bus_q == ST_IDLE);
    assign wr_acc = avs_write && (bus_q == ST_DONE);
    // Reads arm at the take edge, the edge at which their data is caught.
    assign rd_acc = avs_read && acc;

    // Register selects, shared by the write paths and the read mux.
    assign sel_status = addr_is(avs_address, eirq_pkg::OFF_STATUS);
    assign sel_sense  = addr_is(avs_address, eirq_pkg::OFF_SENSE);
    assign sel_evt    = addr_is(avs_address, eirq_pkg::OFF_IRQ_STATUS);
    assign sel_mask   = addr_is(avs_address, eirq_pkg::OFF_IRQ_MASK);

    // Write strobes in the answer cycle, per register and byte lane.
    assign wr_status   = wr_acc && sel_status && avs_byteenable[0];
    assign wr_sense_lo = wr_acc && sel_sense && avs_byteenable[0];
    assign wr_sense_hi = wr_acc && sel_sense && avs_byteenable[1];
    assign wr_evt      = wr_acc && sel_evt && avs_byteenable[0];
    assign wr_mask     = wr_acc && sel_mask && avs_byteenable[0];

    // Bus handshake state.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q <= ST_IDLE;
        end else begin
            case (bus_q)
                ST_IDLE: begin
                    if (acc) begin
                        bus_q <= ST_DONE;
                    end
                end
                ST_DONE: bus_q <= ST_IDLE;
                default: bus_q <= ST_IDLE;
            endcase
        end
    end

    // Waitrequest is high except in the single answer cycle.
    // It stays high in reset, so no access can be answered early.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !acc;
        end
    end

    // Two-stage pin synchroniser and edge history. Reset loads the idle
    // high level, so a pin that idles high shows no false edge after reset
    // and its level flag does not blink.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
        end else begin
            sync1_q <= ext_req_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Transitions seen behind the synchroniser, one vector per direction.
    assign pin_fell = prev_q & ~sync2_q;
    assign pin_rose = ~prev_q & sync2_q;

    // Edge and mode decode per pin.
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            level_mode[i] = (sense_of(sense_q, i) == eirq_pkg::SENSE_LOW);
            case (sense_of(sense_q, i))
                eirq_pkg::SENSE_FALL: edge_hit[i] = pin_fell[i];
                eirq_pkg::SENSE_RISE: edge_hit[i] = pin_rose[i];
                eirq_pkg::SENSE_BOTH: edge_hit[i] = pin_fell[i] | pin_rose[i];
                default:              edge_hit[i] = 1'b0;
            endcase
        end
    end

    // Pin levels in the high byte, flags in the low byte.
    assign status_word = {sync2_q, flag_q};

    // Per-pin arm and clear requests for the edge flags. A status read
    // arms only the flags that its data shows set; a zero-write clears
    // only flags armed that way, and a written one changes nothing.
    always_comb begin
        arm_req = '0;
        zero_wr = '0;
        for (int i = 0; i < NPINS; i++) begin
            arm_req[i] = rd_acc && sel_status && flag_q[i];
            zero_wr[i] = wr_status && !avs_writedata[eirq_pkg::FLAG_LSB + i];
        end
    end

    // Next flag values; a new edge wins over any clear.
    always_comb begin
        flag_d  = flag_q;
        armed_d = armed_q;
        for (int i = 0; i < NPINS; i++) begin
            if (level_mode[i]) begin
                flag_d[i]  = ~sync2_q[i];
                armed_d[i] = 1'b0;
            end else begin
                if (arm_req[i]) begin
                    armed_d[i] = 1'b1;
                end
                if (zero_wr[i] && armed_q[i]) begin
                    flag_d[i]  = 1'b0;
                    armed_d[i] = 1'b0;
                end
                if (irq_accept[i]) begin
                    flag_d[i]  = 1'b0;
                    armed_d[i] = 1'b0;
                end
                if (edge_hit[i]) begin
                    flag_d[i] = 1'b1;
                end
            end
        end
    end

    // Request flags and read-before-clear arming.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q  <= eirq_pkg::FLAG_RESET;
            armed_q <= '0;
        end else begin
            flag_q  <= flag_d;     // writing one leaves a flag unchanged
            armed_q <= armed_d;
        end
    end

    // Flags are also brought out for the interrupt controller.
    // Loaded from the next value, so the output equals the flag register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_flag <= '0;
        end else begin
            req_flag <= flag_d;
        end
    end

    // Sense configuration register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= eirq_pkg::SENSE_RESET;
        end else begin
            // Each byte lane updates its own four pins.
            if (wr_sense_lo) begin
                sense_q[7:0] <= avs_writedata[7:0];
            end
            if (wr_sense_hi) begin
                sense_q[15:8] <= avs_writedata[15:8];
            end
        end
    end

    // A flag rising in this cycle sets its event bit.
    assign flag_rise = flag_d & ~flag_q;

    // Sticky event bits set on each rising flag; write one to clear.
    // A rise in the cycle of a clear wins, so no event is ever lost.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_q <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                if (flag_rise[i]) begin
                    evt_q[i] <= 1'b1;
                end else if (wr_evt && avs_writedata[i]) begin
                    evt_q[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= eirq_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= avs_writedata[7:0];
        end
    end

    // Level interrupt output.
    // It is registered, so it trails the event bits by one cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & mask_q);
        end
    end
    assign irq_out = irq_q;

    // Read multiplexer; offsets without a register read zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (sel_status) begin
            rd_word = {16'h0000, status_word};
        end else if (sel_sense) begin
            rd_word = {16'h0000, sense_q};
        end else if (sel_evt) begin
            rd_word = {24'h00_0000, evt_q};
        end else if (sel_mask) begin
            rd_word = {24'h00_0000, mask_q};
        end
    end

    // Read data captured when the access is taken.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (rd_acc) begin
            rdata_q <= rd_word;
        end
    end
    assign avs_readdata = rdata_q;

endmodule

`default_nettype wire

//--- hw/eirq_pkg.sv
// Package with register map, field layout and reset values of the block.
package eirq_pkg;
    localparam int          NUM_PINS        = 8;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFF_STATUS      = 4'h0;
    localparam logic [3:0]  OFF_SENSE       = 4'h4;
    localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h8;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'hC;
    localparam int          LEVEL_LSB       = 8;
    localparam int          FLAG_LSB        = 0;
    localparam logic [7:0]  FLAG_RESET      = 8'h00;
    localparam logic [15:0] SENSE_RESET     = 16'h0000;
    localparam logic [7:0]  MASK_RESET      = 8'h00;
    localparam logic [1:0]  SENSE_LOW       = 2'b00;
    localparam logic [1:0]  SENSE_FALL      = 2'b01;
    localparam logic [1:0]  SENSE_RISE      = 2'b10;
    localparam logic [1:0]  SENSE_BOTH      = 2'b11;
endpackage

//--- verif/eirq_pins.sv
// Model of the request sources that drive the eight request pins.
`timescale 1ns/100ps
`default_nettype none
module eirq_pins (
    input  wire logic       core_clk,
    input  wire logic [7:0] want,
    output var  logic [7:0] ext_req_pin = 8'hFF
);
    // Sources move their pins just after a clock edge and idle high.
    always @(posedge core_clk) begin
        ext_req_pin <= want;
    end
endmodule
`default_nettype wire

//--- verif/eirq_status_properties.sv
// Checker of bus answers and request flag behaviour at the ports.
`timescale 1ns/100ps
`default_nettype none
module eirq_status_chk #(parameter int NPINS = 8) (
    input wire logic             core_clk,
    input wire logic             arst_n,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic [NPINS-1:0] ext_req_pin,
    input wire logic [NPINS-1:0] irq_accept,
    input wire logic [NPINS-1:0] req_flag
);
    logic [15:0] sense_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Shadow of the sense register, updated at a write's answer edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= 16'h0000;
        end else if (avs_write && !avs_waitrequest && avs_address == 4'h4) begin
            sense_q <= avs_writedata[15:0];
        end
    end
    // A take, the answer cycle, held data, and the flag relations.
    sequence s_take; (avs_read || avs_write) && avs_waitrequest; endsequence
    property p_ans; s_take |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_hold; avs_waitrequest [*2] |-> $stable(avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_gap; avs_read && avs_waitrequest && avs_address == 4'h2
        |=> avs_readdata == '0; endproperty
    a_gap: assert property (p_gap) else $error("hole not zero");
    property p_rst; disable iff (1'b0) !arst_n |-> req_flag == '0; endproperty
    a_rst: assert property (p_rst) else $error("flag in reset");
    property p_lvl; (arst_n && sense_q == 16'h0000) [*5]
        |-> req_flag == ~$past(ext_req_pin, 3); endproperty
    a_lvl: assert property (p_lvl) else $error("level flag");
    property p_stk; $fell(req_flag[0]) && $past(sense_q[1:0]) != 2'b00
        |-> $past(avs_write && !avs_waitrequest || irq_accept[0]); endproperty
    a_stk: assert property (p_stk) else $error("edge flag lost");
    property p_acc; ($stable(ext_req_pin[0]) && sense_q[1:0] != 2'b00) [*4]
        ##0 irq_accept[0] |=> !req_flag[0]; endproperty
    a_acc: assert property (p_acc) else $error("accept kept");
endmodule
bind eirq_status eirq_status_chk #(.NPINS(NPINS)) chk_i (.core_clk(core_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_req_pin(ext_req_pin), .irq_accept(irq_accept), .req_flag(req_flag));
`default_nettype wire

//--- verif/test_eirq_status.sv
// Bench for the request status block and its request sources.
`timescale 1ns/100ps
`default_nettype none
module test_eirq_status;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b1;
    logic [7:0]  flags;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wait_req;
    logic        irq;
    logic [7:0]  want = 8'hFF;
    logic [7:0]  pins;
    logic [7:0]  accept = 8'h00;
    logic [31:0] got;
    int          mismatches = 0;
    int          comparisons = 0;
    // Clock of 40 MHz.
    always #12.5 core_clk = ~core_clk;
    eirq_status uut (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .ext_req_pin(pins),
        .irq_accept(accept), .req_flag(flags), .irq_out(irq));
    eirq_pins src (.core_clk(core_clk), .want(want), .ext_req_pin(pins));
    // One bus access held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        while (wait_req !== 1'b0) @(posedge core_clk);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
    endtask
    // Counts a comparison and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Reads a register and compares it.
    task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, e, got);
    endtask
    // Lets pin changes pass the synchroniser.
    task automatic settle(); repeat (6) @(posedge core_clk); endtask
    // Reset values, hole, then flags following low pins.
    task automatic t_level();
        settle();
        rdchk("status", 4'h0, 32'h0000_FF00);
        rdchk("sense", 4'h4, 32'h0000_0000);
        rdchk("hole", 4'h2, 32'h0000_0000);
        want <= 8'hA5;
        settle();
        rdchk("level", 4'h0, 32'h0000_A55A);
        bus(1'b1, 4'h0, 32'h0000_FF00);
        rdchk("ignored", 4'h0, 32'h0000_A55A);
        want <= 8'hFF;
        settle();
        rdchk("released", 4'h0, 32'h0000_FF00);
    endtask
    // Every edge mode, read-then-zero clearing and acceptance.
    task automatic t_edge();
        bus(1'b1, 4'h4, 32'h0000_3939);
        rdchk("modes", 4'h4, 32'h0000_3939);
        want <= 8'h00;
        settle();
        rdchk("fall", 4'h0, 32'h0000_00DD);
        chk("req_flag", 32'h0000_00DD, {24'h0, flags});
        want <= 8'hFF;
        settle();
        bus(1'b1, 4'h0, 32'h0000_0000);
        rdchk("clear", 4'h0, 32'h0000_FF22);
        accept <= 8'h33;
        @(posedge core_clk);
        accept <= 8'h00;
        @(posedge core_clk);
        rdchk("accept", 4'h0, 32'h0000_FF00);
        chk("req_flag", 32'h0000_0000, {24'h0, flags});
    endtask
    // Interrupt output masked, raised and cleared.
    task automatic t_irq();
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, 4'hC, 32'h0000_00FF);
        repeat (2) @(posedge core_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        rdchk("mask", 4'hC, 32'h0000_00FF);
        bus(1'b1, 4'h8, 32'h0000_00FF);
        repeat (2) @(posedge core_clk);
        chk("irq off", 32'h0, {31'h0, irq});
        rdchk("events", 4'h8, 32'h0000_0000);
    endtask
    // Prints the counts and the verdict.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        arst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_level();
        t_edge();
        t_irq();
        stop_test();
    end
    // Watchdog.
    initial begin
        repeat (2000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
